// ### sacr_map.vh
// constants for the serial converter control and readout block
`ifndef SACR_MAP_VH
`define SACR_MAP_VH

// word layout
`define SACR_WORD_W        16
`define SACR_MSB           15
`define SACR_BIT_IDX_W     4
`define SACR_SYNC_W        7

// synchronised input vector positions
`define SACR_SY_CS_N       0
`define SACR_SY_RC         1
`define SACR_SY_PD         2
`define SACR_SY_TAG        3
`define SACR_SY_EXT        4
`define SACR_SY_FMT        5
`define SACR_SY_SCLK       6

// reset values
`define SACR_RST_WORD      16'h0000
`define SACR_RST_SYNC      7'h07

// timing
`define SACR_CLK_MHZ       125
`define SACR_CONV_TIME_NS  2700
`define SACR_START_MIN_NS  40
`define SACR_CONV_CYC      ((`SACR_CONV_TIME_NS * `SACR_CLK_MHZ) / 1000)
`define SACR_BIT_CYC       (`SACR_CONV_CYC / `SACR_WORD_W)
`define SACR_START_CYC     ((`SACR_START_MIN_NS * `SACR_CLK_MHZ + 999) / 1000)
`define SACR_CYC_W         5
`define SACR_PULSE_RISE    (`SACR_BIT_CYC / 4)
`define SACR_PULSE_FALL    ((3 * `SACR_BIT_CYC) / 4)

// controller states
`define SACR_ST_IDLE       1'b0
`define SACR_ST_CONV       1'b1

`endif

// ### sacr_sync.v
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module sacr_sync #(
  parameter          WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // ----------------------------------------------------------------
  // first stage feeds only the second stage
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// ### sacr_conv.v
// conversion control and serial readout of a 16-bit sar converter
`timescale 1ns/10ps
`include "sacr_map.vh"
module sacr_conv (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        chip_select_n_in,
  input  wire        read_convert_in,
  input  wire        power_down_input_in,
  input  wire        tag_in,
  input  wire        clock_source_select_in,
  input  wire        format_select_in,
  input  wire        shift_clock_in,
  input  wire        comparator_in,
  output wire        busy_n_out,
  output wire        serial_data_out,
  output wire        shift_clock_out,
  output wire        shift_clock_oe_out,
  output wire [15:0] dac_code_out,
  output wire        sample_hold_out,
  output wire        conv_done_out,
  output wire [15:0] result_out
);

  localparam integer           LAST_I   = `SACR_BIT_CYC - 1;
  localparam integer           RISE_I   = `SACR_PULSE_RISE;
  localparam integer           FALL_I   = `SACR_PULSE_FALL;
  localparam [`SACR_CYC_W-1:0] BIT_LAST = LAST_I[`SACR_CYC_W-1:0];
  localparam [`SACR_CYC_W-1:0] P_RISE   = RISE_I[`SACR_CYC_W-1:0];
  localparam [`SACR_CYC_W-1:0] P_FALL   = FALL_I[`SACR_CYC_W-1:0];
  localparam [`SACR_CYC_W-1:0] CYC_ZERO = {`SACR_CYC_W{1'b0}};
  localparam [`SACR_CYC_W-1:0] CYC_ONE  = {{(`SACR_CYC_W-1){1'b0}}, 1'b1};
  localparam [3:0]             IDX_MSB  = 4'hF;
  localparam [3:0]             IDX_ONE  = 4'h1;
  localparam [15:0]            ONE_HOT  = 16'h0001;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  wire [`SACR_SYNC_W-1:0] pins_async;
  wire [`SACR_SYNC_W-1:0] pins_s;

  assign pins_async = {shift_clock_in, format_select_in,
                       clock_source_select_in, tag_in,
                       power_down_input_in, read_convert_in,
                       chip_select_n_in};

  sacr_sync #(
    .WIDTH   (`SACR_SYNC_W),
    .RST_VAL (`SACR_RST_SYNC)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (pins_async),
    .sync_out (pins_s)
  );

  wire cs_n_s = pins_s[`SACR_SY_CS_N];
  wire rc_s   = pins_s[`SACR_SY_RC];
  wire pd_s   = pins_s[`SACR_SY_PD];
  wire tag_s  = pins_s[`SACR_SY_TAG];
  wire ext_s  = pins_s[`SACR_SY_EXT];
  wire fmt_s  = pins_s[`SACR_SY_FMT];
  wire sclk_s = pins_s[`SACR_SY_SCLK];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg                   state_r;
  reg                   state_nxt;
  reg [`SACR_CYC_W-1:0] cyc_r;
  reg [`SACR_CYC_W-1:0] cyc_nxt;
  reg [3:0]             idx_r;
  reg [3:0]             idx_nxt;
  reg [15:0]            sar_r;
  reg [15:0]            sar_nxt;
  reg [15:0]            result_r;
  reg [15:0]            result_nxt;
  reg [15:0]            shift_r;
  reg [15:0]            shift_nxt;
  reg                   tag_hold_r;
  reg                   tag_hold_nxt;
  reg                   int_burst_r;
  reg                   int_burst_nxt;
  reg                   sclk_prev_r;
  reg                   sclk_out_r;
  reg                   sclk_out_nxt;
  reg                   data_r;
  reg                   busy_n_r;
  reg                   done_r;
  reg                   done_nxt;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire start_req = ~pd_s & ~cs_n_s & ~rc_s;
  wire bit_end   = (cyc_r == BIT_LAST);
  wire ext_rise  = sclk_s & ~sclk_prev_r;
  wire read_en   = ~cs_n_s & rc_s;
  wire [15:0] bit_mask = ONE_HOT << idx_r;
  wire [15:0] sar_kept = comparator_in ? sar_r : (sar_r & ~bit_mask);
  // sar code is straight binary, two's complement flips the msb
  wire [15:0] sar_fmt  = {sar_kept[`SACR_MSB] ^ ~fmt_s,
                          sar_kept[14:0]};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always @* begin
    state_nxt     = state_r;
    cyc_nxt       = cyc_r;
    idx_nxt       = idx_r;
    sar_nxt       = sar_r;
    result_nxt    = result_r;
    shift_nxt     = shift_r;
    tag_hold_nxt  = tag_hold_r;
    int_burst_nxt = int_burst_r;
    sclk_out_nxt  = 1'b0;
    done_nxt      = 1'b0;
    case (state_r)
      `SACR_ST_IDLE: begin
        if (start_req) begin
          state_nxt     = `SACR_ST_CONV;
          cyc_nxt       = CYC_ZERO;
          idx_nxt       = IDX_MSB;
          sar_nxt       = 16'h8000;
          tag_hold_nxt  = tag_s;
          int_burst_nxt = ~ext_s;
          if (~ext_s) begin
            shift_nxt = result_r;
          end
        end else if (ext_s & read_en & ext_rise & ~pd_s) begin
          shift_nxt = {shift_r[14:0], tag_s};
        end
      end
      `SACR_ST_CONV: begin
        // further start requests are not looked at here
        cyc_nxt = bit_end ? CYC_ZERO : (cyc_r + CYC_ONE);
        if (int_burst_r) begin
          sclk_out_nxt = (cyc_r >= P_RISE) &&
                         (cyc_r < P_FALL);
        end
        if (bit_end) begin
          if (int_burst_r) begin
            shift_nxt = {shift_r[14:0], tag_hold_r};
          end
          if (idx_r == 4'h0) begin
            state_nxt  = `SACR_ST_IDLE;
            sar_nxt    = sar_kept;
            result_nxt = sar_fmt;
            done_nxt   = 1'b1;
            if (~int_burst_r) begin
              shift_nxt = sar_fmt;
            end
          end else begin
            idx_nxt = idx_r - IDX_ONE;
            sar_nxt = sar_kept | (bit_mask >> 1);
          end
        end else if (~int_burst_r & ext_s & read_en & ext_rise & ~pd_s) begin
          shift_nxt = {shift_r[14:0], tag_s};
        end
      end
      default: begin
        state_nxt = `SACR_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_r     <= `SACR_ST_IDLE;
      cyc_r       <= CYC_ZERO;
      idx_r       <= 4'h0;
      sar_r       <= `SACR_RST_WORD;
      result_r    <= `SACR_RST_WORD;
      shift_r     <= `SACR_RST_WORD;
      tag_hold_r  <= 1'b0;
      int_burst_r <= 1'b0;
      sclk_prev_r <= 1'b0;
      sclk_out_r  <= 1'b0;
      data_r      <= 1'b0;
      busy_n_r    <= 1'b1;
      done_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cyc_r       <= cyc_nxt;
      idx_r       <= idx_nxt;
      sar_r       <= sar_nxt;
      result_r    <= result_nxt;
      shift_r     <= shift_nxt;
      tag_hold_r  <= tag_hold_nxt;
      int_burst_r <= int_burst_nxt;
      sclk_prev_r <= sclk_s;
      sclk_out_r  <= sclk_out_nxt;
      data_r      <= shift_nxt[`SACR_MSB];
      busy_n_r    <= (state_nxt != `SACR_ST_CONV);
      done_r      <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy_n_out         = busy_n_r;
  assign serial_data_out    = data_r;
  assign shift_clock_out    = sclk_out_r;
  assign shift_clock_oe_out = ~ext_s;
  assign dac_code_out       = sar_r;
  assign sample_hold_out    = ~busy_n_r;
  assign conv_done_out      = done_r;
  assign result_out         = result_r;

endmodule

// ### sacr_conv_checker.sv
// port assertions for the converter control block
`timescale 1ns/10ps
module sacr_checker (
  input wire        clk_in,
  input wire        rst_in,
  input wire        power_down_input_in,
  input wire        clock_source_select_in,
  input wire        busy_n_out,
  input wire        serial_data_out,
  input wire        shift_clock_out,
  input wire        shift_clock_oe_out,
  input wire        conv_done_out,
  input wire [15:0] result_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [8:0] low_r;
  logic [4:0] pls_r;
  // ----
  // busy length and pulse counters
  // ----
  always @(posedge clk_in) begin
    if (rst_in || busy_n_out) low_r <= 9'h000;
    else low_r <= low_r + 9'h001;
    if (rst_in || $fell(busy_n_out)) pls_r <= 5'h00;
    else if ($rose(shift_clock_out)) pls_r <= pls_r + 5'h01;
  end
  // ----
  // properties
  // ----
  property p_len; $rose(busy_n_out) |-> low_r == 9'h150; endproperty
  a_len: assert property (p_len) else $error("busy low length");
  property p_done; $rose(busy_n_out) |-> conv_done_out ##1 !conv_done_out;
  endproperty
  a_done: assert property (p_done) else $error("no done pulse");
  property p_pd; $fell(busy_n_out) |->
    !($past(power_down_input_in, 3) && $past(power_down_input_in, 4));
  endproperty
  a_pd: assert property (p_pd) else $error("start in power down");
  property p_oe; clock_source_select_in [*4] |-> !shift_clock_oe_out;
  endproperty
  a_oe: assert property (p_oe) else $error("shift clock driven");
  property p_idle; shift_clock_oe_out && busy_n_out && $past(busy_n_out)
    |-> !shift_clock_out; endproperty
  a_idle: assert property (p_idle) else $error("clock not idle");
  property p_stab; shift_clock_out && shift_clock_oe_out
    |-> $stable(serial_data_out); endproperty
  a_stab: assert property (p_stab) else $error("data moved");
  property p_cnt; $rose(busy_n_out) && shift_clock_oe_out
    |-> pls_r == 5'h10; endproperty
  a_cnt: assert property (p_cnt) else $error("pulse count");
  property p_msb; $fell(busy_n_out) && shift_clock_oe_out
    |=> serial_data_out == result_out[15]; endproperty
  a_msb: assert property (p_msb) else $error("first bit wrong");
endmodule

// ### sacr_host.sv
// host model reading serial words in both clock modes
`timescale 1ns/10ps
module sacr_host (
  input  wire         go_in,
  input  wire         data_in,
  input  wire         dev_clk_in,
  input  wire         dev_oe_in,
  output logic        shift_clk_out,
  output logic [15:0] word_out
);
  logic [15:0] int_word;
  logic [15:0] ext_word;
  // internal mode: sample at rising device clock
  always @(posedge dev_clk_in) begin
    if (dev_oe_in) int_word <= {int_word[14:0], data_in};
  end
  // external mode: 16 pulses at 64 ns, idle low
  initial begin
    shift_clk_out = 1'h0;
    ext_word = 16'h0000;
    forever begin
      @(posedge go_in);
      #5;
      repeat (16) begin
        #32 ext_word = {ext_word[14:0], data_in};
        shift_clk_out = 1'h1;
        #32 shift_clk_out = 1'h0;
      end
    end
  end
  assign word_out = dev_oe_in ? int_word : ext_word;
endmodule

// ### sacr_conv_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module sacr_conv_tb;
  logic        clk_in, rst_in, cs_n, rc, pd, tag, ext, fmt, go, tg;
  logic        cmp = 1'h0;
  wire         busy_n, sdata, sclk_o, sclk_oe, done, hclk, hold;
  wire  [15:0] dac, res, hword;
  logic [15:0] tgt, prev, cur, ev;
  logic [15:0] expq[$];
  int          errors, comparisons, i, k;
  initial begin
    clk_in = 1'h0;
    forever #4 clk_in = ~clk_in;
  end
  sacr_conv i_sacr_conv (.clk_in(clk_in), .rst_in(rst_in),
    .chip_select_n_in(cs_n), .read_convert_in(rc), .power_down_input_in(pd),
    .tag_in(tag), .clock_source_select_in(ext), .format_select_in(fmt),
    .shift_clock_in(hclk), .comparator_in(cmp), .busy_n_out(busy_n),
    .serial_data_out(sdata), .shift_clock_out(sclk_o),
    .shift_clock_oe_out(sclk_oe), .dac_code_out(dac), .sample_hold_out(hold),
    .conv_done_out(done), .result_out(res));
  sacr_host i_sacr_host (.go_in(go), .data_in(sdata), .dev_clk_in(sclk_o),
    .dev_oe_in(sclk_oe), .shift_clk_out(hclk), .word_out(hword));
  // ----
  // comparator and result monitor
  // ----
  always @(negedge clk_in) cmp <= (dac <= tgt);
  always @(negedge clk_in) begin
    if (done === 1'h1) begin
      ev = expq.pop_front();
      `CHK(res, ev)
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic conv(input logic [15:0] t);
    tgt = t;
    cur = fmt ? t : t ^ 16'h8000;
    expq.push_back(cur);
    tg = tag;
    rc = 1'h0;
    cyc(5);
    rc = 1'h1;
    tag = ~tg;
    `CHK(busy_n, 1'h0)
    `CHK(hold, 1'h1)
    cyc(100);
    rc = 1'h0;
    cyc(5);
    rc = 1'h1;
    for (k = 0; k < 500 && busy_n !== 1'h1; k++) cyc(1);
    if (k == 500) errors++;
    cyc(2);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
  initial begin
    {cs_n, pd, tag, ext, fmt, go, tg} = '0;
    {errors, comparisons, tgt, prev, cur} = '0;
    rc = 1'h1;
    rst_in = 1'h1;
    i = $urandom(47943);
    cyc(16);
    rst_in = 1'h0;
    cyc(4);
    for (i = 0; i < 4; i++) begin
      fmt = i[0];
      ext = i[1];
      tag = i[0];
      cyc(4);
      conv(16'($urandom));
      if (!ext) begin
        `CHK(hword, prev)
        `CHK(sdata, tg)
      end else begin
        go = 1'h1;
        cyc(140);
        go = 1'h0;
        `CHK(hword, cur)
      end
      prev = cur;
      $display("test %0d done", i);
    end
    // external mode still selected: convert, leave the result unread
    conv(16'($urandom));
    pd = 1'h1;
    cyc(4);
    rc = 1'h0;
    cyc(10);
    rc = 1'h1;
    cyc(4);
    `CHK(busy_n, 1'h1)
    // clock pulses during power down must not move the result
    go = 1'h1;
    cyc(140);
    go = 1'h0;
    pd = 1'h0;
    cyc(4);
    go = 1'h1;
    cyc(140);
    go = 1'h0;
    `CHK(hword, cur)
    `CHK(res, cur)
    $display("test power down done");
    report_and_stop;
  end
endmodule
bind sacr_conv sacr_checker i_sacr_checker (.clk_in, .rst_in,
  .power_down_input_in, .clock_source_select_in, .busy_n_out,
  .serial_data_out, .shift_clock_out, .shift_clock_oe_out, .conv_done_out,
  .result_out);
